// file: hdl/txg_pkg.sv
/*
 Shared constants for the transmit guard, output shutdown, die temperature
 and DC offset register slice. Assumes byte-wide register access with
 9-bit register addresses at the printed offsets.
*/
package txg_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [8:0] ADDR_SKEW_UPPER   = 9'h11d;
   localparam logic [8:0] ADDR_GUARD_CTRL   = 9'h11f;
   localparam logic [8:0] ADDR_ONOFF_CTRL   = 9'h125;
   localparam logic [8:0] ADDR_AUTO_OFF     = 9'h12c;
   localparam logic [8:0] ADDR_THERM_CTRL   = 9'h12f;
   localparam logic [8:0] ADDR_THERM_LOW    = 9'h132;
   localparam logic [8:0] ADDR_THERM_HIGH   = 9'h133;
   localparam logic [8:0] ADDR_THERM_REFR   = 9'h134;
   localparam logic [8:0] ADDR_OFFS_CTRL    = 9'h135;
   localparam logic [8:0] ADDR_I_WHOLE_LOW  = 9'h136;
   localparam logic [8:0] ADDR_I_WHOLE_HIGH = 9'h137;
   localparam logic [8:0] ADDR_Q_WHOLE_LOW  = 9'h138;
   localparam logic [8:0] ADDR_Q_WHOLE_HIGH = 9'h139;
   localparam logic [8:0] ADDR_I_FRACTION   = 9'h13a;
   localparam logic [8:0] ADDR_Q_FRACTION   = 9'h13b;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_GUARD_CTRL = 8'h83;
   localparam logic [7:0] RST_AUTO_OFF   = 8'h81;
   localparam logic [7:0] RST_THERM_CTRL = 8'h20;
   localparam logic [7:0] RST_ZERO       = 8'h00;
   // ==========================================================
   // Field positions
   localparam int FALL_LSB   = 6;
   localparam int RISE_LSB   = 4;
   localparam int POL_BIT    = 2;
   localparam int SEQ_ON_BIT = 0;
   localparam int FORCE_BIT  = 1;
   localparam int TURNON_BIT = 0;
   localparam int MODE_BIT   = 7;
   localparam int AVG_BIT    = 0;
   // ==========================================================
   // Timing: one delay counter stage length
   localparam int STAGE_NS     = 1000;
   localparam int CLK_NS       = 100;
   localparam int STAGE_CYCLES = (STAGE_NS + CLK_NS - 1) / CLK_NS;
endpackage : txg_pkg

// file: hdl/txg_regs.sv
/*
 Register slice: transmit guard sequencer, output on/off control, automatic
 shutdown, die temperature capture and I/Q DC offset adders.
 Assumes a byte-wide register port in the clk domain, sample data already
 synchronous to clk, and a sensor code that is stable while sampled.
*/
// Functional notes
// RQ1: Bits 4:0 hold skew word bits 12:8; upper bits reserved.
// RQ2: Guard fall delayed by fall-counter count after enable falls; use 1 or 2.
// RQ3: Guard rise delayed by rise-counter count after enable rises; reset 0.
// RQ4: Polarity 0 drives guard low on error; 1 drives high.
// RQ5: Force-off bit shuts output down; 0 allows enable; resets 0.
// RQ6: Turn-on bit self-clears and switches output on unless forced off.
// RQ7: Guard mode high shuts output on monitored error; resets 1.
// RQ8: Power trip with guard mode shuts output on average-power alarm.
// RQ9: Software keeps aux bias field at its reset code 2.
// RQ10: Thermal enable bit powers sensor; resets 0.
// RQ11: Temperature code read as low byte and high byte.
// RQ12: New temperature code captured only on refresh bit rising.
// RQ13: Offset adder acts only when enable bit is 1; resets 0.
// RQ14: I path adds 16-bit signed whole offset.
// RQ15: Q path adds its own 16-bit signed whole offset.
// RQ16: I path adds 5-bit signed fraction in sixteenths.
// RQ17: Q path adds 5-bit signed fraction in sixteenths.
// RQ18: Disabled adder passes samples; enabled applies both offsets together.
// RQ19: Guard follows enable edges only while sequencer bit is set.
`timescale 1ns/1ps
module txg_regs #(
   parameter int DW = 16
) (
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   input  wire logic [8:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   output logic      [7:0]    reg_rdata,
   input  wire logic          transmit_enable_pin,
   input  wire logic          fault_in,
   input  wire logic          avg_power_alarm,
   input  wire logic [15:0]   sensor_code,
   input  wire logic [DW-1:0] i_in,
   input  wire logic [DW-1:0] q_in,
   output logic      [DW-1:0] i_out,
   output logic      [DW-1:0] q_out,
   output logic               tx_guard,
   output logic               output_active,
   output logic               sensor_power,
   output logic      [12:8]   iq_skew_word_hi,
   output logic      [2:0]    aux_adc_bias_code
);
   typedef enum logic [1:0] {
      G_IDLE = 2'b00, G_RISE = 2'b01, G_ON = 2'b10, G_FALL = 2'b11
   } gstate_t;

   // ==========================================================
   // Register storage
   logic [7:0] skew_q, guard_q, onoff_q, auto_q, therm_q, refr_q, offs_q;
   logic [7:0] skew_d, guard_d, onoff_d, auto_d, therm_d, refr_d, offs_d;
   logic [15:0] iw_q, qw_q, iw_d, qw_d, temp_q, temp_d;
   logic [4:0]  ifr_q, qfr_q, ifr_d, qfr_d;
   logic        refr_prev_q, refr_prev_d;

   function automatic logic hit(input logic [8:0] a, input logic [8:0] o);
      hit = reg_wr && (a == o);
   endfunction : hit

   // Write decode; turn-on bit never stored, it is a pulse
   always_comb begin
      skew_d = skew_q;
      guard_d = guard_q;
      onoff_d = onoff_q;
      auto_d = auto_q;
      therm_d = therm_q;
      refr_d = refr_q;
      offs_d = offs_q;
      iw_d = iw_q;
      qw_d = qw_q;
      ifr_d = ifr_q;
      qfr_d = qfr_q;
      if (hit(reg_addr, txg_pkg::ADDR_SKEW_UPPER)) skew_d = reg_wdata; // RQ1
      if (hit(reg_addr, txg_pkg::ADDR_GUARD_CTRL)) guard_d = reg_wdata;
      if (hit(reg_addr, txg_pkg::ADDR_ONOFF_CTRL)) begin
         onoff_d = {reg_wdata[7:1], 1'b0}; // RQ5 RQ6
      end
      if (hit(reg_addr, txg_pkg::ADDR_AUTO_OFF)) auto_d = reg_wdata;
      if (hit(reg_addr, txg_pkg::ADDR_THERM_CTRL)) therm_d = reg_wdata; // RQ9
      if (hit(reg_addr, txg_pkg::ADDR_THERM_REFR)) refr_d = reg_wdata;
      if (hit(reg_addr, txg_pkg::ADDR_OFFS_CTRL)) offs_d = reg_wdata;
      if (hit(reg_addr, txg_pkg::ADDR_I_WHOLE_LOW)) iw_d[7:0] = reg_wdata;
      if (hit(reg_addr, txg_pkg::ADDR_I_WHOLE_HIGH)) iw_d[15:8] = reg_wdata;
      if (hit(reg_addr, txg_pkg::ADDR_Q_WHOLE_LOW)) qw_d[7:0] = reg_wdata;
      if (hit(reg_addr, txg_pkg::ADDR_Q_WHOLE_HIGH)) qw_d[15:8] = reg_wdata;
      if (hit(reg_addr, txg_pkg::ADDR_I_FRACTION)) ifr_d = reg_wdata[4:0];
      if (hit(reg_addr, txg_pkg::ADDR_Q_FRACTION)) qfr_d = reg_wdata[4:0];
   end

   // Temperature capture on refresh rising edge only
   always_comb begin
      refr_prev_d = refr_q[0];
      temp_d = temp_q;
      if (refr_q[0] && !refr_prev_q) temp_d = sensor_code; // RQ12
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         skew_q <= txg_pkg::RST_ZERO;
         guard_q <= txg_pkg::RST_GUARD_CTRL;
         onoff_q <= txg_pkg::RST_ZERO;
         auto_q <= txg_pkg::RST_AUTO_OFF;
         therm_q <= txg_pkg::RST_THERM_CTRL;
         refr_q <= txg_pkg::RST_ZERO;
         offs_q <= txg_pkg::RST_ZERO;
         iw_q <= 16'h0000;
         qw_q <= 16'h0000;
         ifr_q <= 5'h00;
         qfr_q <= 5'h00;
         temp_q <= 16'h0000;
         refr_prev_q <= 1'b0;
      end else begin
         skew_q <= skew_d;
         guard_q <= guard_d;
         onoff_q <= onoff_d;
         auto_q <= auto_d;
         therm_q <= therm_d;
         refr_q <= refr_d;
         offs_q <= offs_d;
         iw_q <= iw_d;
         qw_q <= qw_d;
         ifr_q <= ifr_d;
         qfr_q <= qfr_d;
         temp_q <= temp_d;
         refr_prev_q <= refr_prev_d;
      end
   end

   // ==========================================================
   // Readback (registered data output)
   logic [7:0] rd_d;
   always_comb begin
      case (reg_addr)
         txg_pkg::ADDR_SKEW_UPPER:   rd_d = {3'h0, skew_q[4:0]};
         txg_pkg::ADDR_GUARD_CTRL:   rd_d = guard_q;
         txg_pkg::ADDR_ONOFF_CTRL:   rd_d = onoff_q;
         txg_pkg::ADDR_AUTO_OFF:     rd_d = auto_q;
         txg_pkg::ADDR_THERM_CTRL:   rd_d = therm_q;
         txg_pkg::ADDR_THERM_LOW:    rd_d = temp_q[7:0];  // RQ11
         txg_pkg::ADDR_THERM_HIGH:   rd_d = temp_q[15:8]; // RQ11
         txg_pkg::ADDR_THERM_REFR:   rd_d = refr_q;
         txg_pkg::ADDR_OFFS_CTRL:    rd_d = offs_q;
         txg_pkg::ADDR_I_WHOLE_LOW:  rd_d = iw_q[7:0];
         txg_pkg::ADDR_I_WHOLE_HIGH: rd_d = iw_q[15:8];
         txg_pkg::ADDR_Q_WHOLE_LOW:  rd_d = qw_q[7:0];
         txg_pkg::ADDR_Q_WHOLE_HIGH: rd_d = qw_q[15:8];
         txg_pkg::ADDR_I_FRACTION:   rd_d = {3'h0, ifr_q};
         txg_pkg::ADDR_Q_FRACTION:   rd_d = {3'h0, qfr_q};
         default:                    rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) reg_rdata <= 8'h00;
      else if (reg_rd) reg_rdata <= rd_d;
   end

   // ==========================================================
   // Pin synchronisers
   logic [2:0] s1_q, s2_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
      end else begin
         s1_q <= {transmit_enable_pin, fault_in, avg_power_alarm};
         s2_q <= s1_q;
      end
   end
   wire transmit_enable_pin_s  = s2_q[2];
   wire fault_s = s2_q[1];
   wire avg_s   = s2_q[0];

   // ==========================================================
   // Output on/off state
   logic out_on_q, out_on_d, err;
   always_comb begin
      err = auto_q[txg_pkg::MODE_BIT] && (fault_s ||
            (auto_q[txg_pkg::AVG_BIT] && avg_s)); // RQ7 RQ8
      out_on_d = out_on_q;
      if (hit(reg_addr, txg_pkg::ADDR_ONOFF_CTRL)
          && reg_wdata[txg_pkg::TURNON_BIT]
          && !reg_wdata[txg_pkg::FORCE_BIT]) out_on_d = 1'b1; // RQ6
      if (onoff_q[txg_pkg::FORCE_BIT] || err) out_on_d = 1'b0; // RQ5 RQ7
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) out_on_q <= 1'b1;
      else out_on_q <= out_on_d;
   end
   assign output_active = out_on_q;

   // ==========================================================
   // Guard sequencer: each counter stage is STAGE_CYCLES long
   gstate_t gs_q, gs_d;
   logic [7:0] cnt_q, cnt_d;
   logic       gact_q, gact_d, transmit_enable_pin_prev_q;
   wire  [1:0] rise_n = guard_q[txg_pkg::RISE_LSB +: 2];
   wire  [1:0] fall_n = guard_q[txg_pkg::FALL_LSB +: 2];
   wire        seq_on = guard_q[txg_pkg::SEQ_ON_BIT];

   function automatic logic [7:0] span(input logic [1:0] n);
      span = 8'(n) * 8'(txg_pkg::STAGE_CYCLES);
   endfunction : span

   always_comb begin
      gs_d = gs_q;
      cnt_d = (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
      gact_d = gact_q;
      case (gs_q)
         G_IDLE: if (seq_on && transmit_enable_pin_s && !transmit_enable_pin_prev_q) begin // RQ19
            gs_d = G_RISE;
            cnt_d = span(rise_n); // RQ3
         end
         G_RISE: if (cnt_q == 8'h00) begin
            gs_d = G_ON;
            gact_d = 1'b1;
         end
         // Level test: a fall that came during the rise wait is not lost
         G_ON: if (seq_on && !transmit_enable_pin_s) begin
            gs_d = G_FALL;
            cnt_d = span(fall_n); // RQ2
         end
         G_FALL: if (cnt_q == 8'h00) begin
            gs_d = G_IDLE;
            gact_d = 1'b0;
         end
         default: gs_d = G_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gs_q <= G_IDLE;
         cnt_q <= 8'h00;
         gact_q <= 1'b0;
         transmit_enable_pin_prev_q <= 1'b0;
      end else begin
         gs_q <= gs_d;
         cnt_q <= cnt_d;
         gact_q <= gact_d;
         transmit_enable_pin_prev_q <= transmit_enable_pin_s;
      end
   end

   // Error forces the guard to its safe level set by polarity
   logic guard_d1;
   always_comb begin
      if (err || !out_on_q) guard_d1 = guard_q[txg_pkg::POL_BIT]; // RQ4
      else guard_d1 = gact_q ^ guard_q[txg_pkg::POL_BIT];
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) tx_guard <= 1'b0;
      else tx_guard <= guard_d1;
   end

   // ==========================================================
   // DC offset: fraction kept as 4 extra bits, truncated toward minus infinity at the end
   function automatic logic [DW-1:0] add_off(input logic [DW-1:0] x,
      input logic [15:0] w, input logic [4:0] f);
      logic signed [DW+5:0] acc;
      acc = {{2{x[DW-1]}}, x, 4'h0} + {{(DW-14){w[15]}}, w, 4'h0}
            + {{(DW+1){f[4]}}, f}; // RQ14 RQ16 RQ18
      add_off = acc[DW+3:4];
   endfunction : add_off

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         i_out <= '0;
         q_out <= '0;
      end else if (offs_q[0]) begin // RQ13
         i_out <= add_off(i_in, iw_q, ifr_q); // RQ14 RQ16
         q_out <= add_off(q_in, qw_q, qfr_q); // RQ15 RQ17
      end else begin
         i_out <= i_in; // RQ18
         q_out <= q_in;
      end
   end

   assign sensor_power = therm_q[0]; // RQ10
   assign iq_skew_word_hi = skew_q[4:0];
   assign aux_adc_bias_code = therm_q[6:4];

   // ==========================================================
   // Checks
   a_forceoff_holds: assert property (@(posedge clk) disable iff (!resetn)
      onoff_q[txg_pkg::FORCE_BIT] |=> !output_active)
      else $error("output on while forced off"); // RQ5
   a_turnon_clears: assert property (@(posedge clk) disable iff (!resetn)
      (reg_wr && reg_addr == txg_pkg::ADDR_ONOFF_CTRL
       && reg_wdata[txg_pkg::TURNON_BIT] && !reg_wdata[txg_pkg::FORCE_BIT]
       && !onoff_q[txg_pkg::FORCE_BIT] && !err)
      |=> (output_active && !onoff_q[txg_pkg::TURNON_BIT]))
      else $error("turn-on write did not switch output on"); // RQ6
   a_temp_edge_only: assert property (@(posedge clk) disable iff (!resetn)
      (refr_q[0] && refr_prev_q) |=> $stable(temp_q))
      else $error("temperature changed without edge"); // RQ12
   a_offset_bypass: assert property (@(posedge clk) disable iff (!resetn)
      !offs_q[0] |=> (i_out == $past(i_in) && q_out == $past(q_in)))
      else $error("samples altered with adder off"); // RQ13
   a_error_guard: assert property (@(posedge clk) disable iff (!resetn)
      err |=> tx_guard == $past(guard_q[txg_pkg::POL_BIT]))
      else $error("guard not at error level"); // RQ4
   a_auto_trip: assert property (@(posedge clk) disable iff (!resetn)
      (auto_q[txg_pkg::MODE_BIT] && fault_s) |=> !output_active)
      else $error("no auto shutdown on fault"); // RQ7
   a_rise_wait: assert property (@(posedge clk) disable iff (!resetn)
      (gs_q == G_IDLE && gs_d == G_RISE) |=> cnt_q == $past(span(rise_n)))
      else $error("rise delay count wrong"); // RQ3
   a_seq_off: assert property (@(posedge clk) disable iff (!resetn)
      (!seq_on && gs_q == G_IDLE) |=> gs_q == G_IDLE)
      else $error("sequencer left idle while off"); // RQ19
endmodule : txg_regs

// file: test/analog_side_model.sv
/*
 Far-side model: the die sensor and the guarded analog stage.
 Assumes it shares clk with the register slice and that the bench sets
 the temperature value that the sensor reports.
*/
`timescale 1ns/1ps
module analog_side_model (
   input  wire logic        clk,
   input  wire logic        sensor_power,
   input  wire logic        tx_guard,
   input  wire logic [15:0] temp_value,
   output logic      [15:0] sensor_code,
   output logic             stage_on
);
   // ==========================================================
   // Sensor
   initial sensor_code = 16'h5a5a;
   // Unpowered sensor churns so a stale code can never pass
   always @(posedge clk) begin
      if (sensor_power) begin
         sensor_code <= temp_value;
      end else begin
         sensor_code <= ~sensor_code;
      end
   end
   // ==========================================================
   // Downstream stage follows the guard level
   assign stage_on = tx_guard;
endmodule : analog_side_model

// file: test/tx_guard_offset_temp_regs_tb.sv
/*
 Self-checking bench for the guard, shutdown, temperature and offset
 register slice. Assumes the package, the slice and the far-side model
 are compiled first.
*/
`timescale 1ns/1ps
module tx_guard_offset_temp_regs_tb;
   logic        clk;
   logic        resetn;
   logic        reg_wr;
   logic        reg_rd;
   logic [8:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        pin;
   logic        fault_in;
   logic        alarm;
   logic [15:0] sensor_code;
   logic [15:0] temp_value;
   logic [15:0] i_in;
   logic [15:0] q_in;
   logic [15:0] i_out;
   logic [15:0] q_out;
   logic        tx_guard;
   logic        output_active;
   logic        sensor_power;
   logic        stage_on;
   logic [12:8] skew_hi;
   logic [2:0]  bias;
   int          fail_count;
   int          checked;
   int          cyc;
   // ==========================================================
   // Instances
   txg_regs DUT (.clk(clk), .resetn(resetn), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .transmit_enable_pin(pin),
      .fault_in(fault_in), .avg_power_alarm(alarm),
      .sensor_code(sensor_code), .i_in(i_in), .q_in(q_in),
      .i_out(i_out), .q_out(q_out), .tx_guard(tx_guard),
      .output_active(output_active), .sensor_power(sensor_power),
      .iq_skew_word_hi(skew_hi), .aux_adc_bias_code(bias));
   analog_side_model far (.clk(clk), .sensor_power(sensor_power),
      .tx_guard(tx_guard), .temp_value(temp_value),
      .sensor_code(sensor_code), .stage_on(stage_on));
   // ==========================================================
   // Tasks
   task automatic chk(input string what, input logic [15:0] seen,
                      input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Strobe held from one edge to the taking edge
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [8:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      chk("reg_rdata", 16'(reg_rdata), 16'(exp));
   endtask : rd
   // Lands just past an edge so settled outputs are sampled
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   task automatic conclude();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   // ==========================================================
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         conclude();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      {resetn, reg_wr, reg_rd, pin, fault_in, alarm} = 6'h00;
      reg_addr = 9'h000;
      reg_wdata = 8'h00;
      temp_value = 16'hbeef;
      i_in = 16'h0100;
      q_in = 16'h0100;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      // Reset values and an unmapped place
      rd(9'h11f, 8'h83);
      rd(9'h12c, 8'h81);
      rd(9'h12f, 8'h20);
      rd(9'h135, 8'h00);
      for (int k = 0; k < 4; k++) rd(9'h136 + 9'(k), 8'h00);
      rd(9'h140, 8'h00);
      chk("output_active", 16'(output_active), 16'h0001);
      chk("sensor_power", 16'(sensor_power), 16'h0000);
      chk("bias", 16'(bias), 16'h0002);
      wr(9'h11d, 8'h15);
      wt(2);
      chk("skew_hi", 16'(skew_hi), 16'h0015);
      rd(9'h11d, 8'h15);
      // Offsets: pass-through until the adder is enabled
      wr(9'h136, 8'h34);
      wr(9'h137, 8'h12);
      wr(9'h138, 8'h00);
      wr(9'h139, 8'hff);
      wr(9'h13a, 8'h08);
      wr(9'h13b, 8'h18);
      wt(2);
      chk("i_out", i_out, 16'h0100);
      chk("q_out", q_out, 16'h0100);
      wr(9'h135, 8'h01);
      wt(2);
      chk("i_out", i_out, 16'h1334);
      chk("q_out", q_out, 16'hffff);
      rd(9'h137, 8'h12);
      // Guard: rise one counter, fall two, polarity 0
      wr(9'h11f, 8'h93);
      pin <= 1'b1;
      wt(6);
      chk("tx_guard", 16'(tx_guard), 16'h0000);
      wt(14);
      chk("tx_guard", 16'(tx_guard), 16'h0001);
      chk("stage_on", 16'(stage_on), 16'h0001);
      pin <= 1'b0;
      wt(12);
      chk("tx_guard", 16'(tx_guard), 16'h0001);
      wt(20);
      chk("tx_guard", 16'(tx_guard), 16'h0000);
      // Inverted guard, then an error with each polarity
      wr(9'h11f, 8'h97);
      pin <= 1'b1;
      wt(20);
      chk("tx_guard", 16'(tx_guard), 16'h0000);
      fault_in <= 1'b1;
      wt(5);
      chk("tx_guard", 16'(tx_guard), 16'h0001);
      chk("output_active", 16'(output_active), 16'h0000);
      wr(9'h11f, 8'h93);
      wt(2);
      chk("tx_guard", 16'(tx_guard), 16'h0000);
      fault_in <= 1'b0;
      pin <= 1'b0;
      wt(32);
      // Manual on and off; a turn-on that meets a set force bit is lost
      wr(9'h125, 8'h01);
      wt(2);
      chk("output_active", 16'(output_active), 16'h0001);
      rd(9'h125, 8'h00);
      wr(9'h125, 8'h02);
      wt(2);
      chk("output_active", 16'(output_active), 16'h0000);
      rd(9'h125, 8'h02);
      wr(9'h125, 8'h03);
      wt(2);
      chk("output_active", 16'(output_active), 16'h0000);
      wr(9'h125, 8'h01);
      wt(2);
      chk("output_active", 16'(output_active), 16'h0000);
      wr(9'h125, 8'h01);
      wt(2);
      chk("output_active", 16'(output_active), 16'h0001);
      // Sequencer off with the output on: guard ignores the pin
      wr(9'h11f, 8'h92);
      pin <= 1'b1;
      wt(20);
      chk("tx_guard", 16'(tx_guard), 16'h0000);
      pin <= 1'b0;
      // Automatic shutdown only in guard mode
      wr(9'h12c, 8'h00);
      fault_in <= 1'b1;
      wt(5);
      chk("output_active", 16'(output_active), 16'h0001);
      fault_in <= 1'b0;
      wr(9'h12c, 8'h80);
      alarm <= 1'b1;
      wt(5);
      chk("output_active", 16'(output_active), 16'h0001);
      wr(9'h12c, 8'h81);
      wt(5);
      chk("output_active", 16'(output_active), 16'h0000);
      alarm <= 1'b0;
      // Temperature capture on refresh rising edge only
      wr(9'h12f, 8'h21);
      wt(2);
      chk("sensor_power", 16'(sensor_power), 16'h0001);
      chk("bias", 16'(bias), 16'h0002);
      wr(9'h134, 8'h01);
      wt(3);
      rd(9'h132, 8'hef);
      rd(9'h133, 8'hbe);
      temp_value = 16'h1234;
      wr(9'h134, 8'h01);
      wt(3);
      rd(9'h132, 8'hef);
      wr(9'h134, 8'h00);
      wr(9'h134, 8'h01);
      wt(3);
      rd(9'h132, 8'h34);
      rd(9'h133, 8'h12);
      // Mid-run reset returns the slice to its reset state
      @(posedge clk);
      resetn <= 1'b0;
      wt(2);
      chk("output_active", 16'(output_active), 16'h0001);
      resetn <= 1'b1;
      rd(9'h11f, 8'h83);
      rd(9'h132, 8'h00);
      conclude();
   end
endmodule : tx_guard_offset_temp_regs_tb
